/* rtl/lbr_ctrl.sv */
// Two-bank latching relay bypass controller with APB registers.
// Assumes mode ports and power inputs are asynchronous board pins.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lbr_ctrl #(
  parameter int unsigned TICK_CYC = lbr_pkg::TICK_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      local_reset_n,
  input  wire logic                      board_power_good,
  input  wire logic                      power_fail,
  input  wire logic [3:0]                mode_a,
  input  wire logic [3:0]                mode_b,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [lbr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           relay_normal_a,
  output logic                           relay_bypass_a,
  output logic                           relay_normal_b,
  output logic                           relay_bypass_b,
  output logic                           bank_status_a,
  output logic                           bank_status_b,
  output logic                           bank_a_indicator,
  output logic                           bank_b_indicator
);

  // Prescaler state
  logic [15:0] cyc_r, cyc_nxt;
  logic [9:0]  ms_r, ms_nxt;
  logic        tick_r, tick_nxt, sec_r, sec_nxt;

  // Debounced inputs: [3:0] bank a, [7:4] bank b, 8 good, 9 fail
  logic [9:0] lvl, rise, fall, stab;

  logic        lrst1_r, lrst2_r;
  lbr_pkg::lbr_state_t state_r, state_nxt;
  lbr_pkg::lbr_bank_t  bank_r [2];
  lbr_pkg::lbr_bank_t  bank_nxt [2];
  logic [1:0]  act;
  logic [1:0]  stat_r, stat_nxt, ind_r, ind_nxt;
  logic [15:0] word_r, word_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        hit;

  lbr_debounce #(
    .W (10)
  ) u_deb (
    .clk    (clk),
    .rst    (rst),
    .tick   (tick_r),
    .din    ({power_fail, board_power_good, mode_b, mode_a}),
    .level  (lvl),
    .rise   (rise),
    .fall   (fall),
    .stable (stab)
  );

  // Millisecond and second strobes from the system clock
  always_comb begin
    cyc_nxt  = cyc_r + 16'h0001;
    ms_nxt   = ms_r;
    tick_nxt = 1'b0;
    sec_nxt  = 1'b0;
    if (cyc_r == 16'(TICK_CYC - 1)) begin                 // RULE21
      cyc_nxt  = 16'h0000;
      tick_nxt = 1'b1;
      ms_nxt   = ms_r + 10'h001;
      if (ms_r == 10'(lbr_pkg::MS_PER_S - 1)) begin
        ms_nxt  = 10'h000;
        sec_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_r   <= 16'h0000;
      ms_r    <= 10'h000;
      tick_r  <= 1'b0;
      sec_r   <= 1'b0;
      lrst1_r <= 1'b0;
      lrst2_r <= 1'b0;
    end else begin
      cyc_r   <= cyc_nxt;
      ms_r    <= ms_nxt;
      tick_r  <= tick_nxt;
      sec_r   <= sec_nxt;
      lrst1_r <= local_reset_n;
      lrst2_r <= lrst1_r;
    end
  end

  // Gate on power-good; local reset returns to waiting
  always_comb begin
    state_nxt = state_r;
    if (!lrst2_r)
      state_nxt = lbr_pkg::ST_WAIT;
    else if (state_r == lbr_pkg::ST_WAIT && lvl[8])
      state_nxt = lbr_pkg::ST_RUN;                        // RULE6
  end

  // Per-bank mode, watchdog and coil logic
  always_comb begin
    logic [3:0] code;
    logic       run;
    logic       chg;
    code = 4'h0;
    run  = (state_r == lbr_pkg::ST_RUN);
    chg  = 1'b0;
    for (int i = 0; i < 2; i++) begin                     // RULE16
      bank_nxt[i] = bank_r[i];
      code   = lvl[4*i +: 4];
      chg    = |(rise[4*i +: 4] | fall[4*i +: 4]);
      act[i] = run && bank_r[i].pend && (&stab[4*i +: 4]);  // RULE22
      // Set wins over clear; power-good start forces a read
      bank_nxt[i].pend = (bank_r[i].pend & ~act[i]) | chg
                       | (state_r == lbr_pkg::ST_WAIT);     // RULE7
      // Readout clock: new bit only on a low phase of bit 0
      if (bank_r[i].test && fall[4*i])
        bank_nxt[i].shift = {1'b0, bank_r[i].shift[15:1]}; // RULE4 RULE5
      if (act[i] && !(bank_r[i].trip && code != lbr_pkg::CODE_NORMAL)) begin
        if (code[3:1] != lbr_pkg::PRE_TEST)
          bank_nxt[i].test = 1'b0;
        if (code == lbr_pkg::CODE_NORMAL) begin           // RULE17 RULE11
          bank_nxt[i].bypass = 1'b0;
          bank_nxt[i].trip   = 1'b0;
          bank_nxt[i].wdt_on = 1'b0;
          bank_nxt[i].pf_arm = 1'b0;
        end else if (code == lbr_pkg::CODE_PFARM) begin   // RULE17
          bank_nxt[i].pf_arm = 1'b1;
          bank_nxt[i].wdt_on = 1'b0;
        end else if (code == lbr_pkg::CODE_FORCE) begin   // RULE17
          bank_nxt[i].bypass = 1'b1;
          bank_nxt[i].wdt_on = 1'b0;
        end else if (code[3:2] == lbr_pkg::PRE_WDT) begin // RULE18
          bank_nxt[i].wdt_on = 1'b1;
          bank_nxt[i].pf_arm = 1'b1;
          bank_nxt[i].sel    = code[1:0];
          bank_nxt[i].secs   = lbr_pkg::wdt_period(code[1:0]); // RULE8
        end else if (code[3:1] == lbr_pkg::PRE_TEST) begin
          if (!bank_r[i].test) begin                      // RULE18 RULE5
            bank_nxt[i].test  = 1'b1;
            bank_nxt[i].shift = word_r;
          end
        end else if (code[3:2] == lbr_pkg::PRE_KICK) begin
          // Kick only counts with the armed low bits kept
          if (bank_r[i].wdt_on && code[1:0] == bank_r[i].sel)
            bank_nxt[i].secs =
              lbr_pkg::wdt_period(bank_r[i].sel); // RULE9 RULE19
        end
      end else if (run && sec_r && bank_r[i].wdt_on) begin
        if (bank_r[i].secs <= 5'h01) begin                // RULE10 RULE11
          bank_nxt[i].bypass = 1'b1;
          bank_nxt[i].trip   = 1'b1;
          bank_nxt[i].wdt_on = 1'b0;
          bank_nxt[i].secs   = 5'h00;
        end else begin
          bank_nxt[i].secs = bank_r[i].secs - 5'h01;
        end
      end
      if (run && rise[9] && bank_r[i].pf_arm) begin       // RULE15
        bank_nxt[i].bypass = 1'b1;
        bank_nxt[i].wdt_on = 1'b0;
      end
      // Any change of relay state fires one coil pulse
      if (bank_nxt[i].bypass != bank_r[i].bypass) begin
        bank_nxt[i].pulse    = lbr_pkg::PULSE_TICKS;      // RULE20
        bank_nxt[i].coil_set = ~bank_nxt[i].bypass;       // RULE14
        bank_nxt[i].coil_rst = bank_nxt[i].bypass;        // RULE14
      end else if (tick_r && bank_r[i].pulse != 2'h0) begin
        bank_nxt[i].pulse = bank_r[i].pulse - 2'h1;
        if (bank_r[i].pulse == 2'h1) begin
          bank_nxt[i].coil_set = 1'b0;
          bank_nxt[i].coil_rst = 1'b0;
        end
      end
      if (!lrst2_r)
        bank_nxt[i] = lbr_pkg::BANK_RST;
      stat_nxt[i] = bank_nxt[i].test ? bank_nxt[i].shift[0]
                                     : bank_nxt[i].bypass;  // RULE12
      // Blink at half-second phase while bypassed
      ind_nxt[i] = bank_nxt[i].bypass
                 && (ms_r < 10'(lbr_pkg::BLINK_MS));       // RULE13
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r  <= lbr_pkg::ST_WAIT;
      bank_r   <= '{default: lbr_pkg::BANK_RST};
      stat_r   <= 2'h0;
      ind_r    <= 2'h0;
    end else begin
      state_r  <= state_nxt;
      bank_r   <= bank_nxt;
      stat_r   <= stat_nxt;
      ind_r    <= ind_nxt;
    end
  end

  // APB slave: zero wait states, read data caught in setup
  assign hit = (paddr == lbr_pkg::REG_WORD) || (paddr == lbr_pkg::REG_STATUS)
            || (paddr == lbr_pkg::REG_WDT);

  always_comb begin
    word_nxt = word_r;
    rd_nxt   = rd_r;
    if (psel && penable && pwrite && paddr == lbr_pkg::REG_WORD)
      word_nxt = pwdata[15:0];
    if (psel && !penable) begin
      unique case (paddr)
        lbr_pkg::REG_WORD:   rd_nxt = {16'h0000, word_r};
        lbr_pkg::REG_STATUS: rd_nxt = {20'h00000, state_r,
          bank_r[1].trip, bank_r[1].test, bank_r[1].pf_arm,
          bank_r[1].wdt_on, bank_r[1].bypass, 1'b0,
          bank_r[0].trip, bank_r[0].test, bank_r[0].pf_arm,
          bank_r[0].wdt_on, bank_r[0].bypass};
        lbr_pkg::REG_WDT:    rd_nxt = {19'h00000, bank_r[1].secs,
                                       3'h0, bank_r[0].secs};
        default:             rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_r <= lbr_pkg::WORD_RST;
      rd_r   <= 32'h0000_0000;
    end else begin
      word_r <= word_nxt;
      rd_r   <= rd_nxt;
    end
  end

  assign prdata           = rd_r;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !hit;
  assign relay_normal_a   = bank_r[0].coil_set;
  assign relay_bypass_a   = bank_r[0].coil_rst;
  assign relay_normal_b   = bank_r[1].coil_set;
  assign relay_bypass_b   = bank_r[1].coil_rst;
  assign bank_status_a    = stat_r[0];
  assign bank_status_b    = stat_r[1];
  assign bank_a_indicator = ind_r[0];
  assign bank_b_indicator = ind_r[1];

  // Checks on the tick prescaler and bank a
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clk_high_held;
    bank_r[0].test && lvl[0] ##1 bank_r[0].test;
  endsequence

  sequence s_wdt_enter;
    act[0] && lvl[3:2] == lbr_pkg::PRE_WDT
      && !bank_r[0].trip && !rise[9] && lrst2_r;
  endsequence

  chk_tick_spacing: assert property (tick_r |=> !tick_r [*8]) // RULE21
    else $error("tick strobes too close");
  chk_coil_excl: assert property (!(relay_normal_a && relay_bypass_a)) // RULE14
    else $error("both coils driven");
  chk_wait_quiet: assert property (state_r == lbr_pkg::ST_WAIT
      |-> !relay_normal_a && !relay_bypass_a && !bank_status_a) // RULE6
    else $error("action before power good");
  chk_test_hold: assert property (s_clk_high_held
      |-> $stable(bank_status_a)) // RULE4
    else $error("status moved while clock high");
  chk_wdt_load: assert property (s_wdt_enter
      |=> bank_r[0].wdt_on
          && bank_r[0].secs == lbr_pkg::wdt_period($past(lvl[1:0]))) // RULE8
    else $error("watchdog period not loaded");
  chk_force_code: assert property (act[0] && lvl[3:0] == lbr_pkg::CODE_FORCE
      && lrst2_r
      |=> bank_r[0].bypass ##1 bank_status_a || bank_r[0].test) // RULE17
    else $error("force code did not bypass");
  chk_wdt_expire: assert property (state_r == lbr_pkg::ST_RUN && !act[0]
      && sec_r && bank_r[0].wdt_on && bank_r[0].secs == 5'h01 && lrst2_r
      |=> bank_r[0].bypass && bank_r[0].trip
          && (relay_bypass_a || $past(bank_r[0].bypass))) // RULE10
    else $error("watchdog expiry missed");
  chk_trip_hold: assert property (bank_r[0].trip && lrst2_r
      && !(act[0] && lvl[3:0] == lbr_pkg::CODE_NORMAL)
      |=> bank_r[0].bypass) // RULE11
    else $error("left bypass without normal code");
  chk_pulse_on: assert property (bank_r[0].pulse != 2'h0
      |-> relay_normal_a || relay_bypass_a) // RULE20
    else $error("coil dropped during pulse");
  // Status register loads on the same edge as the bank state
  chk_status_bypass: assert property (!bank_r[0].test
      |-> bank_status_a == bank_r[0].bypass) // RULE12
    else $error("status does not follow relays");

endmodule
`default_nettype wire

/* inc/lbr_pkg.sv */
// Constants, codes and carrier types of the bypass relay controller.
// Assumes a 50 MHz clock and an APB master with 32-bit data.
// Function
// (RULE1) Sample every input once each millisecond, keeping recent samples.
// (RULE2) Accept a rise only after two low samples then a high one.
// (RULE3) Accept a fall only after two high samples then a low one.
// (RULE4) In readout, change status only while mode bit 0 is low.
// (RULE5) Readout shifts the 16-bit checksum LSB first, a bit per bit-0 cycle.
// (RULE6) After local reset, no relay or output action before power-good.
// (RULE7) On power-good, read both mode ports and decide each bank's job.
// (RULE8) Entering a watchdog mode loads the countdown with the coded period.
// (RULE9) A kick reloads the countdown; the partner must kick before expiry.
// (RULE10) Countdown reaching zero switches that bank's relays to bypass.
// (RULE11) After watchdog bypass, stay bypassed until the normal code.
// (RULE12) Status is high while a bank is bypassed, low when normal.
// (RULE13) Each bank has its own indicator that toggles while bypassed.
// (RULE14) Set coil returns relays to normal; reset coil puts them in bypass.
// (RULE15) A falling-rails input triggers bypass in modes armed for it.
// (RULE16) Two independent 4-bit mode ports, each bank handled separately.
// (RULE17) Ignore 0000, 101x; 0001 normal; 0010 arms fail; 0011 bypass.
// (RULE18) 01xx arms watchdog of 5/10/15/20 s; 100x is checksum readout.
// (RULE19) Partner kicks by setting bit 3, keeping bits 2 to 0 constant.
// (RULE20) Each relay switch-over is one 3 ms pulse on the chosen coil.
// (RULE21) Millisecond tick and one-second steps come from a clock prescaler.
// (RULE22) Act on a new code only when all four bits are qualified and agree.
package lbr_pkg;

  // Timing
  localparam int unsigned CLK_NS      = 20;
  localparam int unsigned TICK_NS     = 1_000_000;
  localparam int unsigned TICK_CYC    = TICK_NS / CLK_NS;
  localparam int unsigned MS_PER_S    = 1000;
  localparam int unsigned BLINK_MS    = 500;
  localparam int unsigned PULSE_MS    = 3;
  localparam logic [1:0]  PULSE_TICKS = 2'(PULSE_MS);
  localparam logic [4:0]  WDT_STEP_S  = 5'h05;

  // Mode codes and code prefixes
  localparam logic [3:0] CODE_IDLE   = 4'h0;
  localparam logic [3:0] CODE_NORMAL = 4'h1;
  localparam logic [3:0] CODE_PFARM  = 4'h2;
  localparam logic [3:0] CODE_FORCE  = 4'h3;
  localparam logic [1:0] PRE_WDT     = 2'h1;
  localparam logic [1:0] PRE_KICK    = 2'h3;
  localparam logic [2:0] PRE_TEST    = 3'h4;

  // Register map
  localparam int unsigned ADDR_W     = 12;
  localparam logic [11:0] REG_WORD   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_WDT    = 12'h008;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN  = 1'b1
  } lbr_state_t;

  // Per-bank state
  typedef struct packed {
    logic        bypass;
    logic        trip;
    logic        wdt_on;
    logic        pf_arm;
    logic        test;
    logic [1:0]  sel;
    logic [4:0]  secs;
    logic [1:0]  pulse;
    logic        coil_set;
    logic        coil_rst;
    logic [15:0] shift;
    logic        pend;
  } lbr_bank_t;

  localparam lbr_bank_t BANK_RST = '0;

  // Watchdog period in seconds for a two-bit select
  function automatic logic [4:0] wdt_period(input logic [1:0] sel);
    wdt_period = 5'(({3'h0, sel} + 5'h01) * WDT_STEP_S);
  endfunction

endpackage

/* rtl/lbr_debounce.sv */
// Per-bit synchroniser and three-sample transition qualifier.
// Assumes a one-cycle sample strobe from the same clock domain.
`timescale 1ns/10ps
`default_nettype none
module lbr_debounce #(
  parameter int unsigned W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall,
  output logic      [W-1:0] stable
);

  logic [W-1:0] s1_r, s2_r, h0_r, h1_r, lvl_r, rise_r, fall_r;
  logic [W-1:0] h0_nxt, h1_nxt, lvl_nxt, rise_nxt, fall_nxt;

  // Sample history shifts only on the strobe
  always_comb begin
    h0_nxt   = h0_r;
    h1_nxt   = h1_r;
    lvl_nxt  = lvl_r;
    rise_nxt = '0;
    fall_nxt = '0;
    if (tick) begin
      h0_nxt   = s2_r;                                // RULE1
      h1_nxt   = h0_r;
      rise_nxt = ~h1_r & ~h0_r & s2_r;                // RULE2
      fall_nxt = h1_r & h0_r & ~s2_r;                 // RULE3
      lvl_nxt  = (lvl_r | rise_nxt) & ~fall_nxt;
    end
  end

  // Two-flop sync; s1 feeds s2 only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r   <= '0;
      s2_r   <= '0;
      h0_r   <= '0;
      h1_r   <= '0;
      lvl_r  <= '0;
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      s1_r   <= din;
      s2_r   <= s1_r;
      h0_r   <= h0_nxt;
      h1_r   <= h1_nxt;
      lvl_r  <= lvl_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign level  = lvl_r;
  assign rise   = rise_r;
  assign fall   = fall_r;
  assign stable = ~(h0_r ^ h1_r) & ~(h0_r ^ lvl_r);   // RULE22

endmodule
`default_nettype wire

/* test/lbr_gp_model.sv */
// Model of the two network controllers' general-purpose mode pins.
// Assumes the bench holds each code long enough to be qualified.
`timescale 1ns/10ps
`default_nettype none
module lbr_gp_model (
  input  wire logic       clk,
  output logic      [3:0] mode_a,
  output logic      [3:0] mode_b
);
  // Pins sit low while the controllers power up
  initial begin
    mode_a = 4'h0;
    mode_b = 4'h0;
  end

  // New code just after an edge; caller decides how long it stays
  task automatic send(input int bank, input logic [3:0] code);
    @(posedge clk);
    if (bank == 0) mode_a <= code;
    else mode_b <= code;
  endtask

  // Kick raises bit 3 only, so the armed select is kept
  task automatic kick(input int bank);
    @(posedge clk);
    if (bank == 0) mode_a <= {1'b1, mode_a[2:0]};
    else mode_b <= {1'b1, mode_b[2:0]};
  endtask
endmodule
`default_nettype wire

/* test/test_lan_bypass_relay_controller.sv */
// Self-checking bench for the bypass relay controller.
// Assumes a shortened prescaler: 1 ms is 10 clocks, 1 s 10000.
`timescale 1ns/10ps
`default_nettype none
module test_lan_bypass_relay_controller;
  localparam int MS    = 10;
  localparam int HOLD  = 6 * MS; // Past sync plus three samples
  localparam int LIMIT = 90000;
  logic        clk, rst, local_reset_n, board_power_good, power_fail;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  mode_a, mode_b;
  logic        relay_normal_a, relay_bypass_a, relay_normal_b;
  logic        relay_bypass_b, bank_status_a, bank_status_b;
  logic        bank_a_indicator, bank_b_indicator;
  int          mismatches, n_tests, cycles;

  lbr_ctrl #(.TICK_CYC(MS)) dut (.clk(clk), .rst(rst),
    .local_reset_n(local_reset_n), .board_power_good(board_power_good),
    .power_fail(power_fail), .mode_a(mode_a), .mode_b(mode_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .relay_normal_a(relay_normal_a),
    .relay_bypass_a(relay_bypass_a), .relay_normal_b(relay_normal_b),
    .relay_bypass_b(relay_bypass_b), .bank_status_a(bank_status_a),
    .bank_status_b(bank_status_b), .bank_a_indicator(bank_a_indicator),
    .bank_b_indicator(bank_b_indicator));
  lbr_gp_model gp (.clk(clk), .mode_a(mode_a), .mode_b(mode_b));

  always #10 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check_bit(input string s, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask

  task automatic check_word(input string s, input logic [31:0] e);
    n_tests++;
    if (rd !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, rd);
    end
  endtask

  task automatic check_range(input string s, input int lo, hi, g);
    n_tests++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask

  // One APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic coil(input int k);
    case (k)
      0: coil = relay_normal_a;
      1: coil = relay_bypass_a;
      2: coil = relay_normal_b;
      default: coil = relay_bypass_b;
    endcase
  endfunction

  // Waits for a coil pulse, then measures it in clocks
  task automatic pulse(input string s, input int k, input int bound);
    int n, w;
    n = 0;
    w = 0;
    while (coil(k) !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    while (coil(k) === 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
    check_range(s, 2 * MS - 1, 3 * MS + 1, w);
  endtask

  // No coil may move for n clocks
  task automatic quiet(input string s, input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if ({relay_normal_a, relay_bypass_a, relay_normal_b,
           relay_bypass_b} !== 4'h0) c++;
    end
    check_range(s, 0, 0, c);
  endtask

  task automatic s_power_up;
    gp.send(0, lbr_pkg::CODE_FORCE);
    quiet("coils before power-good", 8 * MS);
    apb(1'b0, lbr_pkg::REG_STATUS, 32'h0);
    check_word("status before power-good", 32'h0);
    board_power_good <= 1'b1;
    pulse("bypass coil a", 1, 10 * MS);
    check_bit("status a", 1'b1, bank_status_a);
    apb(1'b0, lbr_pkg::REG_STATUS, 32'h0);
    check_word("status after power-good", 32'h0000_0801);
  endtask

  task automatic s_normal_and_ignored;
    logic [3:0] codes [3] = '{4'h0, 4'ha, 4'hb};
    gp.send(0, lbr_pkg::CODE_NORMAL);
    pulse("normal coil a", 0, 10 * MS);
    check_bit("status a", 1'b0, bank_status_a);
    foreach (codes[i]) begin
      gp.send(0, codes[i]);
      quiet("coils on ignored code", HOLD);
    end
  endtask

  task automatic s_power_fail;
    gp.send(1, lbr_pkg::CODE_PFARM);
    quiet("coils on arm", HOLD);
    power_fail <= 1'b1;
    pulse("bypass coil b", 3, 10 * MS);
    check_bit("status b", 1'b1, bank_status_b);
    check_bit("status a", 1'b0, bank_status_a);
    power_fail <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask

  task automatic s_readout;
    logic [16:0] sh;
    int ch;
    logic s0;
    sh = 17'h0a5c3;
    apb(1'b1, lbr_pkg::REG_WORD, {15'h0, sh});
    apb(1'b0, lbr_pkg::REG_WORD, 32'h0);
    check_word("checksum word", {15'h0, sh});
    apb(1'b0, 12'h00c, 32'h0);
    check_bit("unmapped error", 1'b1, err);
    check_word("unmapped data", 32'h0);
    gp.send(0, 4'h8);
    repeat (HOLD) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      gp.send(0, 4'h9);
      @(posedge clk);
      s0 = bank_status_a;
      ch = 0;
      repeat (HOLD) begin
        @(posedge clk);
        if (bank_status_a !== s0) ch++;
      end
      check_range("changes while clock high", 0, 0, ch);
      check_bit("readout bit", sh[i], bank_status_a);
      gp.send(0, 4'h8);
      repeat (HOLD) @(posedge clk);
    end
    check_bit("bit after checksum", sh[16], bank_status_a);
    gp.send(0, lbr_pkg::CODE_NORMAL);
    repeat (HOLD) @(posedge clk);
    check_bit("status a after readout", 1'b0, bank_status_a);
  endtask

  task automatic s_watchdog;
    int rb, ha, sa;
    logic pb;
    gp.send(0, 4'h4);
    // Bank b takes the longest period; it never expires in this run
    gp.send(1, 4'h7);
    repeat (HOLD) @(posedge clk);
    apb(1'b0, lbr_pkg::REG_WDT, 32'h0);
    check_word("watchdog load", 32'h0000_1405);
    repeat (10000) @(posedge clk);
    gp.kick(0);
    repeat (HOLD) @(posedge clk);
    apb(1'b0, lbr_pkg::REG_WDT, 32'h0);
    check_word("watchdog reload", 32'h0000_1305);
    gp.send(0, 4'h4);
    rb = 0;
    ha = 0;
    sa = 0;
    pb = bank_b_indicator;
    // Bank b is bypassed meanwhile, so its indicator must blink
    repeat (39000) begin
      @(posedge clk);
      if (bank_b_indicator === 1'b1 && pb === 1'b0) rb++;
      if (bank_a_indicator !== 1'b0) ha++;
      if (bank_status_a !== 1'b0) sa++;
      pb = bank_b_indicator;
    end
    check_range("indicator b blinks", 3, 4, rb);
    check_range("indicator a idle", 0, 0, ha);
    check_range("early expiry", 0, 0, sa);
    pulse("bypass coil on expiry", 1, 12000);
    check_bit("status a tripped", 1'b1, bank_status_a);
    // A watchdog code while tripped must not re-arm the bank
    gp.send(0, 4'h5);
    quiet("coils while tripped", HOLD);
    check_bit("status a held", 1'b1, bank_status_a);
    apb(1'b0, lbr_pkg::REG_STATUS, 32'h0);
    check_word("status while tripped", 32'h0000_09d5);
    gp.send(0, lbr_pkg::CODE_NORMAL);
    pulse("normal coil after trip", 0, 10 * MS);
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    local_reset_n = 1'b0;
    board_power_good = 1'b0;
    power_fail = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    n_tests = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    local_reset_n <= 1'b1;
    s_power_up();
    s_normal_and_ignored();
    s_power_fail();
    s_readout();
    s_watchdog();
    wrap_up();
  end
endmodule
`default_nettype wire
